//--- therm_wake_pkg.sv
// package: constants and carriers for charger wake and thermistor fault logic
package therm_wake_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned OV_RELEASE_MS = 200;
  localparam int unsigned OV_PERIOD_MS = 4000;
  localparam int unsigned OV_RELEASE_CYC = OV_RELEASE_MS * (CLK_HZ / 1000);
  localparam int unsigned OV_PERIOD_CYC = OV_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned CHECK_PERIOD_CYC = 1_000_000;
  localparam int unsigned BIAS_SETTLE_CYC = 1000;
  localparam int unsigned FILTER_CYC = 5_000_000;
  localparam int unsigned SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    PWR_SHUTDOWN = 2'b00,
    PWR_ACTIVE   = 2'b01,
    PWR_LOWPOWER = 2'b10
  } pwr_state_e;

  typedef enum logic [2:0] {
    CHK_IDLE     = 3'b000,
    CHK_EXT_SENSE = 3'b001,
    CHK_BIAS     = 3'b010,
    CHK_CLASSIFY = 3'b011
  } chk_state_e;

  // comparator outputs from the thermistor analog front end
  typedef struct packed {
    logic above_ext_pullup;
    logic above_open;
    logic below_hot;
    logic below_short;
  } therm_cmp_s;

  typedef struct packed {
    logic over_temp;
    logic open_or_cold;
    logic shorted;
  } therm_fault_s;
endpackage

//--- charger_wake_thermistor_faults.sv
// charger wake, power state and thermistor fault classification
`timescale 1ns/1ps
module charger_wake_thermistor_faults #(
  parameter int unsigned CHECK_PERIOD = therm_wake_pkg::CHECK_PERIOD_CYC,
  parameter int unsigned BIAS_SETTLE = therm_wake_pkg::BIAS_SETTLE_CYC,
  parameter int unsigned FILTER = therm_wake_pkg::FILTER_CYC,
  parameter int unsigned OV_PERIOD = therm_wake_pkg::OV_PERIOD_CYC,
  parameter int unsigned OV_RELEASE = therm_wake_pkg::OV_RELEASE_CYC
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // analog comparator inputs (asynchronous)
  input wire logic i_charger_sense_pin,
  input wire logic i_charger_return_pin,
  input wire therm_wake_pkg::therm_cmp_s i_thermistor_input,
  // configuration
  input wire logic i_ov_signal_via_thermistor,
  input wire logic i_temp_monitor_disable,
  input wire logic i_shutdown_on_fault,
  input wire logic i_ov_fault,
  // outputs
  output logic o_internal_regulator,
  output logic o_charge_fet_drive,
  output logic o_discharge_fet_drive,
  output logic o_thermistor_bias_output,
  output logic o_thermistor_pull_low,
  output therm_wake_pkg::pwr_state_e o_pwr_state,
  output therm_wake_pkg::therm_fault_s o_therm_fault,
  output logic o_charger_present
);
  import therm_wake_pkg::*;

  // three-stage synchronisers; changes count when stages two and three agree
  logic [SYNC_STAGES-1:0] chg_sync_r, ret_sync_r;
  logic [SYNC_STAGES-1:0] cmp_sync_r [4];
  logic chg_lvl_r, ret_lvl_r;
  logic [3:0] cmp_lvl_r;
  logic [3:0] cmp_raw;
  assign cmp_raw = i_thermistor_input;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chg_sync_r <= '0;
      ret_sync_r <= '0;
      for (int k = 0; k < 4; k++) begin
        cmp_sync_r[k] <= '0;
      end
    end else begin
      chg_sync_r <= {chg_sync_r[SYNC_STAGES-2:0], i_charger_sense_pin};
      ret_sync_r <= {ret_sync_r[SYNC_STAGES-2:0], i_charger_return_pin};
      for (int k = 0; k < 4; k++) begin
        cmp_sync_r[k] <= {cmp_sync_r[k][SYNC_STAGES-2:0], cmp_raw[k]};
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chg_lvl_r <= 1'b0;
      ret_lvl_r <= 1'b0;
      cmp_lvl_r <= '0;
    end else begin
      if (chg_sync_r[1] == chg_sync_r[2]) begin
        chg_lvl_r <= chg_sync_r[2];
      end
      if (ret_sync_r[1] == ret_sync_r[2]) begin
        ret_lvl_r <= ret_sync_r[2];
      end
      for (int k = 0; k < 4; k++) begin
        if (cmp_sync_r[k][1] == cmp_sync_r[k][2]) begin
          cmp_lvl_r[k] <= cmp_sync_r[k][2];
        end
      end
    end
  end

  therm_cmp_s cmp;
  assign cmp = cmp_lvl_r;

  // overvoltage pull-down with periodic release window
  logic pull_active;
  logic [31:0] ov_cnt_r;
  logic in_release;
  assign pull_active = i_ov_signal_via_thermistor && i_ov_fault;
  assign in_release = ov_cnt_r < OV_RELEASE;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ov_cnt_r <= '0;
    end else if (!pull_active) begin
      ov_cnt_r <= 32'(OV_RELEASE); // first pull starts at once
    end else if (ov_cnt_r >= OV_PERIOD - 1) begin
      ov_cnt_r <= '0;
    end else begin
      ov_cnt_r <= ov_cnt_r + 32'd1;
    end
  end

  // charger detection: continuous, or only in release window while pulling
  logic chg_detect;
  assign chg_detect = chg_lvl_r && (!pull_active || in_release);

  logic chg_prev_r;
  logic chg_rise;
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chg_prev_r <= 1'b0;
    end else begin
      chg_prev_r <= chg_detect;
    end
  end
  // fresh detection only, so a charger left attached does not re-wake after a short
  assign chg_rise = chg_detect && !chg_prev_r;

  // periodic thermistor check
  chk_state_e chk_r;
  logic [31:0] chk_cnt_r;
  logic ext_bias_r;
  logic monitor_on;
  assign monitor_on = (o_pwr_state != PWR_SHUTDOWN) && !i_temp_monitor_disable && !pull_active;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chk_r <= CHK_IDLE;
      chk_cnt_r <= '0;
      ext_bias_r <= 1'b0;
    end else if (!monitor_on) begin
      chk_r <= CHK_IDLE;
      chk_cnt_r <= '0;
    end else begin
      case (chk_r)
        CHK_IDLE: begin
          if (chk_cnt_r >= CHECK_PERIOD - 1) begin
            chk_cnt_r <= '0;
            chk_r <= CHK_EXT_SENSE;
          end else begin
            chk_cnt_r <= chk_cnt_r + 32'd1;
          end
        end
        CHK_EXT_SENSE: begin
          ext_bias_r <= cmp.above_ext_pullup;
          chk_r <= CHK_BIAS;
        end
        CHK_BIAS: begin
          if (chk_cnt_r >= BIAS_SETTLE - 1) begin
            chk_cnt_r <= '0;
            chk_r <= CHK_CLASSIFY;
          end else begin
            chk_cnt_r <= chk_cnt_r + 32'd1;
          end
        end
        CHK_CLASSIFY: begin
          chk_r <= CHK_IDLE;
        end
        default: begin
          chk_r <= CHK_IDLE;
        end
      endcase
    end
  end

  // bias pulsed only inside a check and only without external supply
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_thermistor_bias_output <= 1'b0;
    end else begin
      o_thermistor_bias_output <= monitor_on && !ext_bias_r &&
        (chk_r == CHK_BIAS || chk_r == CHK_CLASSIFY);
    end
  end

  // fault classification and filter-time recovery of open/cold fault
  logic [31:0] open_clr_r;
  logic short_hit;
  assign short_hit = (chk_r == CHK_CLASSIFY) && cmp.below_short && o_pwr_state != PWR_SHUTDOWN;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_therm_fault <= '0;
      open_clr_r <= '0;
    end else if (i_temp_monitor_disable || o_pwr_state == PWR_SHUTDOWN) begin
      o_therm_fault <= '0;
      open_clr_r <= '0;
    end else if (chk_r == CHK_CLASSIFY) begin
      o_therm_fault.shorted <= cmp.below_short;
      o_therm_fault.over_temp <= cmp.below_hot && !cmp.below_short;
      if (cmp.above_open) begin
        o_therm_fault.open_or_cold <= 1'b1;
        open_clr_r <= '0;
      end
    end else if (o_therm_fault.open_or_cold && !cmp.above_open) begin
      if (open_clr_r >= FILTER - 1) begin
        o_therm_fault.open_or_cold <= 1'b0;
        open_clr_r <= '0;
      end else begin
        open_clr_r <= open_clr_r + 32'd1;
      end
    end else begin
      open_clr_r <= '0;
    end
  end

  // a return-pin wake is not latched; a fresh charger detection makes it stick
  logic ret_wake_r;
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ret_wake_r <= 1'b0;
    end else if (o_pwr_state == PWR_SHUTDOWN) begin
      ret_wake_r <= ret_lvl_r && !chg_rise;
    end else if (chg_rise) begin
      ret_wake_r <= 1'b0;
    end
  end

  // power state
  logic any_fault;
  assign any_fault = |o_therm_fault;
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pwr_state <= PWR_SHUTDOWN;
    end else begin
      case (o_pwr_state)
        PWR_SHUTDOWN: begin
          if (chg_rise || ret_lvl_r) begin
            o_pwr_state <= PWR_ACTIVE;
          end
        end
        PWR_ACTIVE, PWR_LOWPOWER: begin
          if (short_hit) begin
            o_pwr_state <= PWR_SHUTDOWN;
          end else if (ret_wake_r && !ret_lvl_r && !chg_rise) begin
            o_pwr_state <= PWR_SHUTDOWN;
          end else if (o_therm_fault.open_or_cold && !chg_lvl_r && !ret_lvl_r) begin
            // overtemperature alone keeps the device active
            o_pwr_state <= i_shutdown_on_fault ? PWR_SHUTDOWN : PWR_LOWPOWER;
          end else if (o_pwr_state == PWR_LOWPOWER && chg_rise) begin
            o_pwr_state <= PWR_ACTIVE;
          end
        end
        default: begin
          o_pwr_state <= PWR_SHUTDOWN;
        end
      endcase
    end
  end

  // outputs
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_internal_regulator <= 1'b0;
      o_charge_fet_drive <= 1'b0;
      o_discharge_fet_drive <= 1'b0;
      o_thermistor_pull_low <= 1'b0;
      o_charger_present <= 1'b0;
    end else begin
      o_internal_regulator <= o_pwr_state != PWR_SHUTDOWN;
      // both FETs wait for the regulator and open on any thermal fault
      o_charge_fet_drive <= o_internal_regulator && o_pwr_state == PWR_ACTIVE && !any_fault;
      o_discharge_fet_drive <= o_internal_regulator && o_pwr_state == PWR_ACTIVE && !any_fault;
      o_thermistor_pull_low <= pull_active && !in_release;
      o_charger_present <= chg_detect;
    end
  end

  a_fet_reg_off: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !o_internal_regulator |=> !o_charge_fet_drive && !o_discharge_fet_drive)
    else $error("fet driven while regulator off");
  a_hot_fets_off: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_therm_fault.over_temp |=> !o_charge_fet_drive && !o_discharge_fet_drive)
    else $error("fets on during overtemperature");
  a_short_shutdown: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    short_hit |=> o_pwr_state == PWR_SHUTDOWN)
    else $error("short did not shut down");
  a_bias_in_check: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_thermistor_bias_output |-> $past(chk_r == CHK_BIAS || chk_r == CHK_CLASSIFY))
    else $error("bias outside check");
  a_ext_no_bias: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (chk_r == CHK_BIAS && ext_bias_r) |=> !o_thermistor_bias_output)
    else $error("bias on with external supply");
  a_ov_pull: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (pull_active && !in_release) |=> o_thermistor_pull_low)
    else $error("no pull during overvoltage");
  a_pull_no_sense: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_thermistor_pull_low |-> !$past(chg_detect))
    else $error("sensing while pulling low");
  a_release_window: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $rose(pull_active && in_release) |-> (pull_active && in_release)[*8])
    else $error("release window too short");
  a_ret_wake: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (o_pwr_state == PWR_SHUTDOWN && ret_lvl_r) |=> o_pwr_state == PWR_ACTIVE)
    else $error("return pin did not wake");
  a_open_state: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_therm_fault.open_or_cold |-> o_pwr_state != PWR_SHUTDOWN || $past(o_pwr_state) != PWR_SHUTDOWN)
    else $error("open fault slept device");
endmodule

//--- charger_therm_model.sv
// far-side model: external charger and pack thermistor network
`timescale 1ns/1ps
module charger_therm_model
  import therm_wake_pkg::*;
(
  // bench control
  input wire logic i_charger_on,
  input wire logic [1:0] i_temp_code,
  // device lines
  input wire logic i_bias_on,
  input wire logic i_pull_low,
  // to device
  output logic o_sense,
  output therm_cmp_s o_cmp,
  output logic o_charging
);
  assign o_sense = i_charger_on;
  always_comb begin
    o_cmp = '0;
    // unbiased or pulled line sinks to ground, never keeps a stale level
    if (i_pull_low || !(i_charger_on || i_bias_on)) begin
      o_cmp.below_hot = 1'b1;
      o_cmp.below_short = 1'b1;
    end else begin
      o_cmp.above_ext_pullup = i_charger_on;
      o_cmp.above_open = (i_temp_code == 2'd2);
      o_cmp.below_hot = i_temp_code[0];
      o_cmp.below_short = (i_temp_code == 2'd3);
    end
  end
  // charger halts while the line reads hot
  assign o_charging = i_charger_on & ~o_cmp.below_hot;
endmodule

//--- tb_top.sv
// testbench for charger wake and thermistor fault logic
`timescale 1ns/1ps
module tb_top;
  import therm_wake_pkg::*;
  localparam int unsigned CP = 20;
  // settle must cover the bias register plus the input synchroniser latency
  localparam int unsigned BS = 8;
  // filter longer than a check period, so unbiased idle readings cannot clear a fault
  localparam int unsigned FL = 100;
  localparam int unsigned OP = 100;
  localparam int unsigned OR = 20;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic chg_on = 1'b0;
  logic [1:0] temp = 2'd0;
  logic ov_cfg = 1'b0;
  logic tmp_dis = 1'b0;
  logic ov_flt = 1'b0;
  logic ret_pin = 1'b0;
  logic sleep_cfg = 1'b0;
  logic sense, charging, reg_en, cfet, dfet, bias, pull, present;
  therm_cmp_s cmp;
  pwr_state_e pwr;
  therm_fault_s flt;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  charger_therm_model u_far (.i_charger_on(chg_on), .i_temp_code(temp), .i_bias_on(bias),
    .i_pull_low(pull), .o_sense(sense), .o_cmp(cmp), .o_charging(charging));
  charger_wake_thermistor_faults #(.CHECK_PERIOD(CP), .BIAS_SETTLE(BS), .FILTER(FL),
    .OV_PERIOD(OP), .OV_RELEASE(OR)) u_dut (.i_core_clk(clk), .i_arst_n(arst_n),
    .i_charger_sense_pin(sense), .i_charger_return_pin(ret_pin), .i_thermistor_input(cmp),
    .i_ov_signal_via_thermistor(ov_cfg), .i_temp_monitor_disable(tmp_dis),
    .i_shutdown_on_fault(sleep_cfg), .i_ov_fault(ov_flt), .o_internal_regulator(reg_en),
    .o_charge_fet_drive(cfet), .o_discharge_fet_drive(dfet),
    .o_thermistor_bias_output(bias), .o_thermistor_pull_low(pull), .o_pwr_state(pwr),
    .o_therm_fault(flt), .o_charger_present(present));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // bias cycles over n cycles
  task automatic count_bias(input int n, output int c);
    c = 0;
    repeat (n) begin
      step(1);
      c += bias;
    end
  endtask
  task automatic t_wake();
    int c;
    check("pwr", pwr, PWR_SHUTDOWN);
    check("fets", {cfet, dfet}, 2'b00);
    chg_on = 1'b1;
    step(10);
    check("pwr", pwr, PWR_ACTIVE);
    check("reg", reg_en, 1'b1);
    count_bias(CP * 3, c);
    check("ext bias", c, 0);
    check("fets", {cfet, dfet}, 2'b11);
    chg_on = 1'b0;
    count_bias(CP * 4, c);
    check("own bias", (c > 0) && (c <= 4 * (BS + 2)), 1'b1);
    $display("test wake done");
  endtask
  task automatic t_temp();
    temp = 2'd1;
    step(CP * 3);
    check("hot", {flt.over_temp, cfet, dfet}, 3'b100);
    check("pwr", pwr, PWR_ACTIVE);
    temp = 2'd0;
    step(CP * 3);
    temp = 2'd2;
    step(CP * 3);
    check("open", {flt.open_or_cold, cfet, dfet}, 3'b100);
    check("pwr", pwr, PWR_LOWPOWER);
    temp = 2'd0;
    step(FL + CP * 2 + 10);
    check("open clr", flt.open_or_cold, 1'b0);
    $display("test temp done");
  endtask
  task automatic t_ov();
    int lows;
    int run;
    int bad;
    lows = 0;
    run = 0;
    bad = 0;
    chg_on = 1'b1;
    tmp_dis = 1'b1;
    ov_cfg = 1'b1;
    ov_flt = 1'b1;
    step(OP + 5);
    repeat (2 * OP) begin
      step(1);
      lows += !pull;
      run = pull ? run + 1 : 0;
      if (run > 6 && (present || charging)) bad++;
    end
    check("release", lows, 2 * OR);
    check("gated", bad, 0);
    ov_flt = 1'b0;
    ov_cfg = 1'b0;
    tmp_dis = 1'b0;
    step(10);
    check("pull off", pull, 1'b0);
    $display("test ov done");
  endtask
  task automatic t_short();
    temp = 2'd3;
    step(CP * 3);
    check("pwr", pwr, PWR_SHUTDOWN);
    check("off", {reg_en, cfet, dfet}, 3'b000);
    temp = 2'd0;
    step(CP * 2);
    check("no wake", pwr, PWR_SHUTDOWN);
    chg_on = 1'b0;
    step(10);
    chg_on = 1'b1;
    step(10);
    check("rewake", pwr, PWR_ACTIVE);
    $display("test short done");
  endtask
  task automatic t_ret();
    temp = 2'd3;
    step(CP * 3);
    check("pwr", pwr, PWR_SHUTDOWN);
    temp = 2'd0;
    ret_pin = 1'b1;
    step(10);
    check("ret wake", pwr, PWR_ACTIVE);
    check("reg", reg_en, 1'b1);
    ret_pin = 1'b0;
    step(10);
    check("ret drop", pwr, PWR_SHUTDOWN);
    check("reg", reg_en, 1'b0);
    $display("test return wake done");
  endtask
  task automatic t_sleep();
    sleep_cfg = 1'b1;
    temp = 2'd2;
    chg_on = 1'b0;
    step(10);
    chg_on = 1'b1;
    step(CP * 3);
    check("pwr", pwr, PWR_ACTIVE);
    check("open", flt.open_or_cold, 1'b1);
    chg_on = 1'b0;
    step(10);
    check("sleep", pwr, PWR_SHUTDOWN);
    sleep_cfg = 1'b0;
    temp = 2'd0;
    $display("test fault sleep done");
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    step(16);
    arst_n = 1'b1;
    step(2);
    t_wake();
    t_temp();
    t_ov();
    t_short();
    t_ret();
    t_sleep();
    report_and_stop();
  end
endmodule
